// ===== spc_pkg.sv
// Shared constants for the parallel-side clocking and transfer port.
// Assumes three-level select pins arrive already encoded as two-bit codes.
package spc_pkg;
    localparam int NUM_CH    = 4;            // Number of channels.
    localparam int CHAR_W    = 10;           // Width of one character.
    localparam int BUF_DEPTH = 4;            // Phase-align buffer depth.
    localparam int BUF_HALF  = 2;            // Fill level set while retuning.
    localparam int HCNT_W    = 8;            // Width of the half-period counter.

    // Encodings of a three-level select pin.
    localparam logic [1:0] SEL_LOW  = 2'h0;
    localparam logic [1:0] SEL_MID  = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;

    // Serial bit clock multipliers of the reference clock.
    localparam logic [4:0] MULT_HIGH = 5'h14;
    localparam logic [4:0] MULT_LOW  = 5'h0A;

    // Values after reset.
    localparam logic [CHAR_W-1:0] RST_CHAR = 10'h000;
    localparam logic [HCNT_W-1:0] RST_HCNT = 8'h00;
    localparam logic [4:0]        RST_MULT = 5'h0A;
endpackage : spc_pkg

// ===== spc_parallel_clocking_port.sv
// Parallel-side clocking and transfer logic of a four-channel 10-bit link port.
// Assumes every pin input is asynchronous to i_core_clk and is far slower than it,
// so that edges of the reference and channel clocks are seen by oversampling.
`timescale 1ns/1ps
`default_nettype none
module spc_parallel_clocking_port #(
    parameter int NCH   = spc_pkg::NUM_CH,
    parameter int DEPTH = spc_pkg::BUF_DEPTH
) (
    input  wire logic                                  i_core_clk,
    input  wire logic                                  i_reset_n,
    input  wire logic                                  i_reference_clock_in,
    input  wire logic [NCH-1:0]                        i_tx_channel_input_clock,
    input  wire logic                                  i_tx_phase_align_reset_n,
    input  wire logic [1:0]                            i_tx_input_clock_select,
    input  wire logic                                  i_tx_rate_select,
    input  wire logic                                  i_rx_ref_timed,
    input  wire logic [1:0]                            i_parity_control,
    input  wire logic [NCH-1:0]                        i_rx_recovered_clock,
    input  wire logic [NCH-1:0][spc_pkg::CHAR_W-1:0]   i_tx_char_in,
    input  wire logic [NCH-1:0]                        i_tx_odd_parity_in,
    input  wire logic [NCH-1:0][spc_pkg::CHAR_W-1:0]   i_rx_framed_char,
    input  wire logic [spc_pkg::CHAR_W-1:0]            i_framing_char,
    output logic      [NCH-1:0][spc_pkg::CHAR_W-1:0]   o_tx_shift_char,
    output logic      [NCH-1:0]                        o_tx_shift_valid,
    output logic      [NCH-1:0]                        o_tx_parity_error_flag,
    output logic                                       o_tx_char_clock_out,
    output logic      [4:0]                            o_bit_clock_multiplier,
    output logic      [NCH-1:0]                        o_rx_output_clock,
    output logic      [NCH-1:0][spc_pkg::CHAR_W-1:0]   o_rx_char_out,
    output logic      [NCH-1:0]                        o_framing_match_flag,
    output logic      [NCH-1:0]                        o_rx_odd_parity_out,
    output logic      [NCH-1:0]                        o_rx_odd_parity_oe
);
    import spc_pkg::*;

    localparam int CW = CHAR_W;
    localparam int AW = $clog2(DEPTH);
    localparam int SW = 8 + 3 * NCH + 2 * NCH * CW + CW;

    typedef logic [AW:0] spc_ptr_t;

    // Every pin input except i_reset_n passes two flip-flops before any logic reads it.
    logic [SW-1:0] sync1_q;
    logic [SW-1:0] sync2_q;
    wire  [SW-1:0] async_v = {i_reference_clock_in, i_tx_channel_input_clock,
                              i_tx_phase_align_reset_n, i_tx_input_clock_select,
                              i_tx_rate_select, i_rx_ref_timed, i_parity_control,
                              i_rx_recovered_clock, i_tx_char_in, i_tx_odd_parity_in,
                              i_rx_framed_char, i_framing_char};

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= async_v;
            sync2_q <= sync1_q;
        end
    end

    logic                    ref_s;
    logic [NCH-1:0]          txclk_s;
    logic                    align_rst_n_s;
    logic [1:0]              sel_s;
    logic                    rate_s;
    logic                    rx_ref_s;
    logic [1:0]              parity_control_s;
    logic [NCH-1:0]          rxclk_s;
    logic [NCH-1:0][CW-1:0]  txd_s;
    logic [NCH-1:0]          txp_s;
    logic [NCH-1:0][CW-1:0]  rxd_s;
    logic [CW-1:0]           frame_s;

    // Unpack the synchronised pin vector.
    assign {ref_s, txclk_s, align_rst_n_s, sel_s, rate_s, rx_ref_s, parity_control_s,
            rxclk_s, txd_s, txp_s, rxd_s, frame_s} = sync2_q;

    // Edge detection on the synchronised clocks.
    logic           ref_prev_q;
    logic [NCH-1:0] txclk_prev_q;
    logic [NCH-1:0] rxclk_prev_q;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ref_prev_q   <= 1'b0;
            txclk_prev_q <= '0;
            rxclk_prev_q <= '0;
        end else begin
            ref_prev_q   <= ref_s;
            txclk_prev_q <= txclk_s;
            rxclk_prev_q <= rxclk_s;
        end
    end

    wire            ref_rise   = ref_s & ~ref_prev_q;
    wire            ref_fall   = ~ref_s & ref_prev_q;
    wire            ref_edge   = ref_rise | ref_fall;
    wire [NCH-1:0]  txclk_rise = txclk_s & ~txclk_prev_q;
    wire [NCH-1:0]  rxclk_rise = rxclk_s & ~rxclk_prev_q;
    wire            par_on     = (parity_control_s != SEL_LOW);
    wire            buf_on     = (sel_s != SEL_LOW);
    // Character tick runs at bit clock over ten: twice the reference in high rate.
    wire            char_tick  = ref_rise | (rate_s & ref_fall);

    // Character clock output: follows the reference at full rate; at double rate
    // it rises on each reference edge and falls halfway through the measured half period.
    logic [HCNT_W-1:0] hcnt_q;
    logic [HCNT_W-1:0] hlen_q;
    logic              char_clk_q;
    wire               hcnt_max = &hcnt_q;
    wire               half_hit = (hcnt_q == (hlen_q >> 1));

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hcnt_q     <= RST_HCNT;
            hlen_q     <= RST_HCNT;
            char_clk_q <= 1'b0;
        end else begin
            hcnt_q <= ref_edge ? RST_HCNT : (hcnt_max ? hcnt_q : hcnt_q + 1'b1);
            if (ref_edge) begin
                hlen_q <= hcnt_q;
            end
            if (!rate_s) begin
                char_clk_q <= ref_s;
            end else if (ref_edge) begin
                char_clk_q <= 1'b1;
            end else if (half_hit) begin
                char_clk_q <= 1'b0;
            end
        end
    end

    // Serial bit clock multiplier handed to the transmit clock synthesiser.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_bit_clock_multiplier <= RST_MULT;
        end else begin
            o_bit_clock_multiplier <= rate_s ? MULT_HIGH : MULT_LOW;
        end
    end

    assign o_tx_char_clock_out = char_clk_q;

    // Per-channel input register write enables from the selected clock source.
    logic [NCH-1:0] wr_en;
    logic [NCH-1:0] full;
    logic [NCH-1:0] empty;
    logic [NCH-1:0] par_bad;
    spc_ptr_t       wr_ptr_q [NCH];
    spc_ptr_t       rd_ptr_q [NCH];
    spc_ptr_t       wr_next  [NCH];
    logic [CW:0]    buf_q    [NCH][DEPTH];
    logic [NCH-1:0] slip_q;

    for (genvar c = 0; c < NCH; c++) begin : g_tx
        assign wr_en[c] = (sel_s == SEL_LOW) ? char_tick :
                          (sel_s == SEL_MID) ? txclk_rise[c] :
                                               txclk_rise[0];
        assign full[c]    = (spc_ptr_t'(wr_ptr_q[c] - rd_ptr_q[c]) == spc_ptr_t'(DEPTH));
        assign empty[c]   = (wr_ptr_q[c] == rd_ptr_q[c]);
        assign wr_next[c] = wr_en[c] ? spc_ptr_t'(wr_ptr_q[c] + 1'b1) : wr_ptr_q[c];
        assign par_bad[c] = par_on & ~(^buf_q[c][rd_ptr_q[c][AW-1:0]]);
    end

    // Phase-align buffers: written on the selected clock source, drained on the character tick.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int c = 0; c < NCH; c++) begin
                wr_ptr_q[c] <= '0;
                rd_ptr_q[c] <= '0;
                for (int d = 0; d < DEPTH; d++) begin
                    buf_q[c][d] <= '0;
                end
            end
            slip_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                // A full buffer still takes the write when the reader frees that slot.
                if (wr_en[c] && (!full[c] || char_tick || !align_rst_n_s)) begin
                    buf_q[c][wr_ptr_q[c][AW-1:0]] <= {txp_s[c], txd_s[c]};
                end
                if (!align_rst_n_s) begin
                    // Retune: hold the read side half a buffer behind the writer.
                    wr_ptr_q[c] <= wr_next[c];
                    rd_ptr_q[c] <= spc_ptr_t'(wr_next[c] - spc_ptr_t'(BUF_HALF));
                    slip_q[c]   <= 1'b0;
                end else begin
                    // Phase relationship frozen: pointers only step, never realign.
                    if (wr_en[c] && (!full[c] || char_tick)) begin
                        wr_ptr_q[c] <= wr_next[c];
                    end
                    if (char_tick && !empty[c]) begin
                        rd_ptr_q[c] <= spc_ptr_t'(rd_ptr_q[c] + 1'b1);
                    end
                    if (buf_on && ((wr_en[c] && full[c] && !char_tick) ||
                                   (char_tick && empty[c] && !wr_en[c]))) begin
                        slip_q[c] <= 1'b1;
                    end
                end
            end
        end
    end

    // Characters to the shifter, with the error flag per character period.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_tx_shift_char        <= {NCH{RST_CHAR}};
            o_tx_shift_valid       <= '0;
            o_tx_parity_error_flag <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                o_tx_shift_valid[c] <= char_tick;
                if (char_tick) begin
                    o_tx_shift_char[c]        <= buf_q[c][rd_ptr_q[c][AW-1:0]][CW-1:0];
                    o_tx_parity_error_flag[c] <= slip_q[c] | par_bad[c];
                end else begin
                    o_tx_parity_error_flag[c] <= slip_q[c] | (o_tx_parity_error_flag[c] & ~ref_edge);
                end
            end
        end
    end

    // Receive side: output clock and the tick that times the data registers.
    logic [NCH-1:0] rx_tick;
    logic [NCH-1:0] rxclk_d;

    for (genvar c = 0; c < NCH; c++) begin : g_rx
        localparam bit AC = (c == 0) || (c == 2);
        assign rx_tick[c] = rx_ref_s ? ref_rise : rxclk_rise[c];
        assign rxclk_d[c] = !rx_ref_s ? rxclk_s[c] :
                            (AC && rate_s) ? (o_rx_output_clock[c] ^ ref_rise) :
                            ref_s;
    end

    logic [NCH-1:0] rx_tick_q;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rx_output_clock    <= '0;
            rx_tick_q            <= '0;
            o_rx_char_out        <= {NCH{RST_CHAR}};
            o_framing_match_flag <= '0;
            o_rx_odd_parity_out  <= '0;
            o_rx_odd_parity_oe   <= '0;
        end else begin
            o_rx_output_clock  <= rxclk_d;
            rx_tick_q          <= rx_tick;
            o_rx_odd_parity_oe <= {NCH{par_on}};
            for (int c = 0; c < NCH; c++) begin
                // Data moves the cycle after the output clock edge: a rise, or either edge on channels 0 and 2 at high rate when reference-timed.
                if (rx_tick_q[c]) begin
                    o_rx_char_out[c]        <= rxd_s[c];
                    o_framing_match_flag[c] <= (rxd_s[c] == frame_s);
                    o_rx_odd_parity_out[c]  <= ~(^rxd_s[c]);
                end else begin
                    o_framing_match_flag[c] <= (o_rx_char_out[c] == frame_s);
                end
            end
        end
    end

endmodule // spc_parallel_clocking_port
`default_nettype wire

// ===== spc_parallel_clocking_port_properties.sv
// Concurrent checks on the outputs of the parallel clocking port.
// Assumes the design top module and is attached to it by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module spc_parallel_clocking_port_properties #(
    parameter int NCH = spc_pkg::NUM_CH
) (
    input wire logic                                i_core_clk,
    input wire logic                                i_reset_n,
    input wire logic                                i_tx_phase_align_reset_n,
    input wire logic                                i_tx_rate_select,
    input wire logic [1:0]                          i_parity_control,
    input wire logic [spc_pkg::CHAR_W-1:0]          i_framing_char,
    input wire logic [NCH-1:0][spc_pkg::CHAR_W-1:0] o_tx_shift_char,
    input wire logic [NCH-1:0]                      o_tx_shift_valid,
    input wire logic [NCH-1:0]                      o_tx_parity_error_flag,
    input wire logic [4:0]                          o_bit_clock_multiplier,
    input wire logic [NCH-1:0]                      o_rx_output_clock,
    input wire logic [NCH-1:0][spc_pkg::CHAR_W-1:0] o_rx_char_out,
    input wire logic [NCH-1:0]                      o_framing_match_flag,
    input wire logic [NCH-1:0]                      o_rx_odd_parity_out,
    input wire logic [NCH-1:0]                      o_rx_odd_parity_oe
);
    import spc_pkg::*;
    logic [3:0] up_q;
    wire        ready;
    // Counts cycles after reset so the pin synchronisers have filled.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            up_q <= 4'h0;
        end else if (up_q != 4'hF) begin
            up_q <= up_q + 4'h1;
        end
    end
    assign ready = (up_q == 4'hF);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);
    a_mult_rate: assert property (
        $changed(o_bit_clock_multiplier) |->
        o_bit_clock_multiplier == ($past(i_tx_rate_select, 3) ? MULT_HIGH : MULT_LOW))
        else $error("Bit clock multiplier disagrees with rate select.");
    // Every channel gets the same set of output checks.
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        a_valid_pulse: assert property (
            o_tx_shift_valid[c] |=> !o_tx_shift_valid[c])
            else $error("Shifter valid lasted more than one cycle.");
        a_char_hold: assert property (
            $changed(o_tx_shift_char[c]) |-> o_tx_shift_valid[c])
            else $error("Shifter character moved without a valid pulse.");
        a_slip_sticky: assert property (
            (i_tx_phase_align_reset_n && i_parity_control == 2'h0)[*4]
            ##0 o_tx_parity_error_flag[c] |=> o_tx_parity_error_flag[c])
            else $error("Slip flag dropped while phase reset stayed high.");
        a_rx_after_clk: assert property (
            $changed(o_rx_char_out[c]) |->
            $past(o_rx_output_clock[c]) != $past(o_rx_output_clock[c], 2))
            else $error("Receive data changed without a receive clock edge.");
        a_frame_match: assert property (
            ready && $stable(i_framing_char)[*4] ##0 $stable(o_rx_char_out[c]) |->
            o_framing_match_flag[c] == (o_rx_char_out[c] == i_framing_char))
            else $error("Framing flag disagrees with the output character.");
        a_parity_value: assert property (
            o_rx_odd_parity_oe[c] && $stable(o_rx_char_out[c]) |->
            o_rx_odd_parity_out[c] == ~^o_rx_char_out[c])
            else $error("Receive parity is not odd over the character.");
        a_parity_enable: assert property (
            $changed(o_rx_odd_parity_oe[c]) |->
            o_rx_odd_parity_oe[c] == ($past(i_parity_control, 3) != 2'h0))
            else $error("Parity driver enable disagrees with parity control.");
    end
endmodule // spc_parallel_clocking_port_properties
bind spc_parallel_clocking_port spc_parallel_clocking_port_properties #(.NCH(NCH)) u_props (.*);
`default_nettype wire

// ===== spc_host_model.sv
// Host side model: reference, channel and recovered clocks and characters.
// Assumes a core clock far faster than the clocks it makes.
`timescale 1ns/1ps
`default_nettype none
module spc_host_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_fast,
    output logic            o_ref,
    output logic [3:0]      o_txclk,
    output logic [3:0][9:0] o_txchar,
    output logic [3:0]      o_txpar,
    output logic [3:0][9:0] o_rxchar
);
    logic [2:0] ph_q  = 3'h0;
    logic [2:0] fph_q = 3'h0;
    wire  [2:0] ph1   = ph_q + 3'h1;
    wire  [2:0] ph3   = ph_q + 3'h3;
    // Phase counters; a fast channel one breaks coherence on request.
    always @(posedge i_core_clk) begin
        ph_q  <= ph_q + 3'h1;
        fph_q <= (fph_q == 3'h5) ? 3'h0 : fph_q + 3'h1;
    end
    // Channel 0 equals the reference; the others are offset in phase, channel 1 faster when i_fast is set.
    assign o_ref   = ph_q[2];
    assign o_txclk = {ph3[2], ph1[2], i_fast ? (fph_q >= 3'h3) : ph1[2], ph_q[2]};
    // Each channel steps its character on its own falling clock edge.
    for (genvar c = 0; c < 4; c++) begin : g_ch
        logic       prev_q = 1'b0;
        logic [9:0] cnt_q  = 10'h000;
        always @(posedge i_core_clk) begin
            prev_q <= o_txclk[c];
            cnt_q  <= (prev_q && !o_txclk[c]) ? cnt_q + 10'h001 : cnt_q;
        end
        // Slipped or repeated characters are harmless to this model.
        assign o_txchar[c] = cnt_q;
        assign o_txpar[c]  = ~^cnt_q;
        assign o_rxchar[c] = cnt_q & 10'h00F;
    end
endmodule // spc_host_model
`default_nettype wire

// ===== spc_parallel_clocking_port_bench.sv
// Self-checking bench for the parallel clocking port with the host model.
// Assumes the design and model files are compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module spc_parallel_clocking_port_bench;
    import spc_pkg::*;
    logic            clk = 1'b0, rst_n = 1'b0, pa_rst_n = 1'b0, rate = 1'b0;
    logic            ref_timed = 1'b1, fast = 1'b0, ref_clk, cclk;
    logic [1:0]      sel = SEL_LOW, pctl = SEL_LOW;
    logic [9:0]      frame_char = 10'h005;
    logic [3:0]      tx_clk, tx_par, perr, valid, rx_clk, fm, rpar, roe;
    logic [3:0][9:0] tx_char, rx_in, sh_char, rx_char;
    logic [4:0]      mult;
    int              num_errors = 0, check_count = 0, cycles = 0, ra, rb, rc, hits;
    spc_host_model host (.i_core_clk(clk), .i_fast(fast), .o_ref(ref_clk), .o_txclk(tx_clk),
        .o_txchar(tx_char), .o_txpar(tx_par), .o_rxchar(rx_in));
    spc_parallel_clocking_port dut (.i_core_clk(clk), .i_reset_n(rst_n),
        .i_reference_clock_in(ref_clk), .i_tx_channel_input_clock(tx_clk),
        .i_tx_phase_align_reset_n(pa_rst_n), .i_tx_input_clock_select(sel),
        .i_tx_rate_select(rate), .i_rx_ref_timed(ref_timed), .i_parity_control(pctl),
        .i_rx_recovered_clock(tx_clk), .i_tx_char_in(tx_char), .i_tx_odd_parity_in(tx_par),
        .i_rx_framed_char(rx_in), .i_framing_char(frame_char), .o_tx_shift_char(sh_char),
        .o_tx_shift_valid(valid), .o_tx_parity_error_flag(perr), .o_tx_char_clock_out(cclk),
        .o_bit_clock_multiplier(mult), .o_rx_output_clock(rx_clk), .o_rx_char_out(rx_char),
        .o_framing_match_flag(fm), .o_rx_odd_parity_out(rpar), .o_rx_odd_parity_oe(roe));
    always #5 clk = ~clk;
    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Counts receive clock rises on A and B, character clock rises and framing hits on A.
    task automatic count_rises(input int n);
        logic pa, pb, pc;
        ra = 0;
        rb = 0;
        rc = 0;
        hits = 0;
        pa = rx_clk[0];
        pb = rx_clk[1];
        pc = cclk;
        repeat (n) begin
            @(posedge clk);
            #1;
            ra += int'(rx_clk[0] && !pa);
            rb += int'(rx_clk[1] && !pb);
            rc += int'(cclk && !pc);
            hits += int'(fm[0]);
            pa = rx_clk[0];
            pb = rx_clk[1];
            pc = cclk;
        end
    endtask
    // Takes two shifter pulses on one channel; the host steps its character by one each.
    task automatic check_step(input string name, input int ch);
        logic [9:0] first;
        do begin
            @(posedge clk);
            #1;
        end while (!valid[ch]);
        first = sh_char[ch];
        do begin
            @(posedge clk);
            #1;
        end while (!valid[ch]);
        check(name, first + 10'h001, sh_char[ch]);
    endtask
    // Picks a clock source, pulses the phase-align reset, then lets traffic run.
    task automatic retune(input logic [1:0] s, input logic f);
        @(posedge clk);
        sel <= s;
        fast <= f;
        pa_rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        pa_rst_n <= 1'b1;
        repeat (300) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence: rates, receive outputs, then clock sources and slips.
    initial begin
        repeat (4) @(posedge clk);
        #1;
        check("mult_in_reset", 10'h00A, 10'(mult));
        check("oe_in_reset", 10'h000, 10'(roe));
        @(posedge clk);
        rst_n <= 1'b1;
        rate <= 1'b1;
        count_rises(160);
        check("mult_high", 10'h014, 10'(mult));
        check("rxclk_half", 10'h001, 10'(ra * 2 + 3 >= rb && ra * 2 <= rb + 3));
        check("cclk_double", 10'h001, 10'(rc + 3 >= rb * 2 && rc <= rb * 2 + 3));
        @(posedge clk);
        rate <= 1'b0;
        count_rises(160);
        check("mult_low", 10'h00A, 10'(mult));
        check("rxclk_full", 10'h001, 10'(ra + 2 >= rb && rb + 2 >= ra));
        check("cclk_single", 10'h001, 10'(rc + 2 >= rb && rb + 2 >= rc));
        check("frame_seen", 10'h001, 10'(hits > 0 && hits < 80));
        check("parity_off", 10'h000, 10'(roe));
        @(posedge clk);
        pctl <= SEL_MID;
        count_rises(40);
        check("parity_on", 10'h00F, 10'(roe));
        @(posedge clk);
        pctl <= SEL_LOW;
        retune(SEL_LOW, 1'b1);
        check("slip_sel_low", 10'h000, 10'(perr));
        check_step("step_sel_low", 0);
        retune(SEL_HIGH, 1'b1);
        check("slip_sel_high", 10'h000, 10'(perr));
        check_step("step_sel_high", 0);
        retune(SEL_MID, 1'b1);
        check("slip_sel_mid", 10'h002, 10'(perr));
        check_step("step_sel_mid", 0);
        retune(SEL_MID, 1'b0);
        check("slip_cleared", 10'h000, 10'(perr));
        check_step("step_recovered", 1);
        // Receive outputs timed by the recovered clocks instead of the reference.
        @(posedge clk);
        ref_timed <= 1'b0;
        count_rises(80);
        check("rxclk_recovered", 10'h001, 10'(ra + 2 >= rb && rb + 2 >= ra && ra > 5));
        give_verdict();
    end
endmodule // spc_parallel_clocking_port_bench
`default_nettype wire
